// ===== core/ecgtr_regs.sv
// Summary of operation
// - A conversion above full scale minus the high margin times 64 flags range error.
// - A conversion below zero scale plus the low margin times 64 flags range error.
// - In ac mode a value at or above the high limit times 512 codes flags lead-off.
// - In ac mode a value at or below the low limit times 512 codes flags lead-off.
// - Each pace channel has an 8-bit edge limit, zero meaning half the amplitude limit.
// - Each pace channel has a signed 8-bit level limit in LSBs.
// - Channel values are msb-justified in bits 23:0 at every rate.
// - Electrode and analog lead formats give unsigned values.
// - Digital lead format gives twos complement values.
// - At the fastest rate 16 bits are significant, otherwise 24.
// - A frame read at the fastest rate returns only the upper 16 bits of the read word: the address tag and sample bits 23:16.
// - A 2-bit field picks the rate, and the fastest rate forces electrode format.
`timescale 1ns/10ps
`include "ecgtr_map.svh"
module ecgtr_regs #(
  parameter int DW = 24
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // serial register port, decoded
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic frame_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic rd_short,
  // mode inputs
  input wire logic [1:0] output_rate_select,
  input wire logic output_format_select,
  input wire logic ac_leadoff_mode,
  input wire logic [7:0] pace_amplitude_limit,
  // conversions
  input wire logic [2:0] conv_valid,
  input wire logic [3*DW-1:0] conv_data,
  input wire logic [2:0] chan_enable,
  input wire logic flag_clear,
  // results
  output logic [2:0] range_err,
  output logic [2:0] leadoff,
  output logic [23:0] pace_edge_eff,
  output logic [23:0] pace_level_limits
);
  ////////////////////////////////////////////////////////////////////////////
  logic [19:0] ac_leadoff_high_limit, ac_leadoff_low_limit;
  logic [23:0] pace_edge_limits;
  logic [19:0] next_high, next_low;
  logic [23:0] next_edge, next_level, next_edge_eff;
  logic [31:0] next_rdata;
  logic next_rvalid, next_short;
  logic fast, signed_fmt;
  logic [DW-1:0] sample [3];

  always_comb begin
    fast = output_rate_select == ecgtr_pkg::ECGTR_RATE_128K;
    // fastest rate only runs in electrode format
    signed_fmt = !output_format_select && !fast;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_high = ac_leadoff_high_limit;
    next_low = ac_leadoff_low_limit;
    next_edge = pace_edge_limits;
    next_level = pace_level_limits;
    if (reg_wr) begin
      // reserved nibble is not stored; host keeps it zero
      case (reg_addr)
        `ECGTR_ADDR_HIGH_LIMIT: next_high = reg_wdata[19:0];
        `ECGTR_ADDR_LOW_LIMIT: next_low = reg_wdata[19:0];
        `ECGTR_ADDR_EDGE: next_edge = reg_wdata;
        `ECGTR_ADDR_LEVEL: next_level = reg_wdata;
        default: next_high = ac_leadoff_high_limit;
      endcase
    end
    for (int i = 0; i < 3; i++) begin
      // zero picks half the amplitude limit
      if (pace_edge_limits[8*i +: 8] == 8'h00) begin
        next_edge_eff[8*i +: 8] = {1'b0, pace_amplitude_limit[7:1]};
      end else begin
        next_edge_eff[8*i +: 8] = pace_edge_limits[8*i +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ac_leadoff_high_limit <= `ECGTR_HIGH_RST;
      ac_leadoff_low_limit <= `ECGTR_LOW_RST;
      pace_edge_limits <= `ECGTR_EDGE_RST;
      pace_level_limits <= `ECGTR_LEVEL_RST;
      pace_edge_eff <= 24'h000000;
    end else begin
      ac_leadoff_high_limit <= next_high;
      ac_leadoff_low_limit <= next_low;
      pace_edge_limits <= next_edge;
      pace_level_limits <= next_level;
      pace_edge_eff <= next_edge_eff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_rdata = 32'h00000000;
    case (reg_addr)
      `ECGTR_ADDR_HIGH_LIMIT: next_rdata = {12'h000, ac_leadoff_high_limit};
      `ECGTR_ADDR_LOW_LIMIT: next_rdata = {12'h000, ac_leadoff_low_limit};
      `ECGTR_ADDR_EDGE: next_rdata = {8'h00, pace_edge_limits};
      `ECGTR_ADDR_LEVEL: next_rdata = {8'h00, pace_level_limits};
      `ECGTR_ADDR_CH1: next_rdata = {`ECGTR_ADDR_CH1, sample[0]};
      `ECGTR_ADDR_CH2: next_rdata = {`ECGTR_ADDR_CH2, sample[1]};
      `ECGTR_ADDR_CH3: next_rdata = {`ECGTR_ADDR_CH3, sample[2]};
      default: next_rdata = 32'h00000000;
    endcase
    next_short = 1'b0;
    if (frame_rd && fast) begin
      // frame slot is 16 bits wide: upper half moves to the low half
      next_rdata = {16'h0000, next_rdata[31:16]};
      next_short = 1'b1;
    end
    if (!reg_rd) begin
      next_rdata = reg_rdata;
      next_short = rd_short;
    end
    next_rvalid = reg_rd;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
      rd_short <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
      rd_short <= next_short;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  for (genvar g = 0; g < 3; g++) begin : g_chan
    ecgtr_chan #(.DW(DW)) u_chan (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .conv_valid(conv_valid[g]),
      .conv_data(conv_data[DW*g +: DW]),
      .chan_enable(chan_enable[g]),
      .signed_fmt(signed_fmt),
      .short_word(fast),
      .ac_mode(ac_leadoff_mode),
      .high_margin(ac_leadoff_high_limit[`ECGTR_MARGIN_MSB:`ECGTR_MARGIN_LSB]),
      .low_margin(ac_leadoff_low_limit[`ECGTR_MARGIN_MSB:`ECGTR_MARGIN_LSB]),
      .high_limit(ac_leadoff_high_limit[`ECGTR_LIMIT_MSB:`ECGTR_LIMIT_LSB]),
      .low_limit(ac_leadoff_low_limit[`ECGTR_LIMIT_MSB:`ECGTR_LIMIT_LSB]),
      .flag_clear(flag_clear),
      .sample(sample[g]),
      .range_err(range_err[g]),
      .leadoff(leadoff[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checking helpers for channel one
  logic [DW:0] ob0;
  logic [3:0] hm, lm;
  logic take0;
  always_comb begin
    ob0 = {1'b0, (signed_fmt ? {~conv_data[DW-1], conv_data[DW-2:0]} : conv_data[DW-1:0])};
    hm = ac_leadoff_high_limit[`ECGTR_MARGIN_MSB:`ECGTR_MARGIN_LSB];
    lm = ac_leadoff_low_limit[`ECGTR_MARGIN_MSB:`ECGTR_MARGIN_LSB];
    take0 = conv_valid[0] && chan_enable[0];
  end

  property p_over;
    @(posedge sys_clk) disable iff (!nrst)
    (take0 && hm != 4'h0 && ob0 > ({1'b0, {DW{1'b1}}} - (DW+1)'(hm) * 64)) |=> range_err[0];
  endproperty
  a_over: assert property (p_over) else $error("overrange not flagged");

  property p_under;
    @(posedge sys_clk) disable iff (!nrst)
    (take0 && lm != 4'h0 && ob0 < (DW+1)'(lm) * 64) |=> range_err[0];
  endproperty
  a_under: assert property (p_under) else $error("underrange not flagged");

  property p_no_range;
    @(posedge sys_clk) disable iff (!nrst)
    (hm == 4'h0 && lm == 4'h0 && !range_err[0]) |=> !range_err[0];
  endproperty
  a_no_range: assert property (p_no_range) else $error("range flag with checks off");

  property p_lof_hi;
    @(posedge sys_clk) disable iff (!nrst)
    (take0 && ac_leadoff_mode && ob0 >= (DW+1)'(ac_leadoff_high_limit[15:0]) * 512)
      |=> leadoff[0];
  endproperty
  a_lof_hi: assert property (p_lof_hi) else $error("upper lead-off missed");

  property p_lof_lo;
    @(posedge sys_clk) disable iff (!nrst)
    (take0 && ac_leadoff_mode && ob0 <= (DW+1)'(ac_leadoff_low_limit[15:0]) * 512)
      |=> leadoff[0];
  endproperty
  a_lof_lo: assert property (p_lof_lo) else $error("lower lead-off missed");

  property p_tag;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_rd && !frame_rd && reg_addr == `ECGTR_ADDR_CH2)
      |=> reg_rvalid && reg_rdata[31:24] == `ECGTR_ADDR_CH2;
  endproperty
  a_tag: assert property (p_tag) else $error("channel read lacks address tag");

  property p_short;
    @(posedge sys_clk) disable iff (!nrst)
    (take0 && fast) |=> sample[0][7:0] == 8'h00 ##1 (sample[0][7:0] == 8'h00 || $past(take0));
  endproperty
  a_short: assert property (p_short) else $error("fast rate kept low bits");

  property p_frame;
    @(posedge sys_clk) disable iff (!nrst)
    (reg_rd && frame_rd && fast) |=> rd_short && reg_rdata[31:16] == 16'h0000;
  endproperty
  a_frame: assert property (p_frame) else $error("frame read not shortened");

  property p_edge;
    @(posedge sys_clk) disable iff (!nrst)
    // nrst in the antecedent keeps the release edge, still in reset, out of it
    (nrst && pace_edge_limits[7:0] == 8'h00)
      |=> pace_edge_eff[7:0] == $past(pace_amplitude_limit) / 2;
  endproperty
  a_edge: assert property (p_edge) else $error("zero edge limit not halved");

  c_range: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(range_err[0]));
  c_lof: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(leadoff[1]));
  c_frame: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(rd_short));
endmodule : ecgtr_regs

// ===== core/ecgtr_map.svh
`ifndef ECGTR_MAP_SVH
`define ECGTR_MAP_SVH
// register addresses on the serial register port
`define ECGTR_ADDR_HIGH_LIMIT 8'h0c
`define ECGTR_ADDR_LOW_LIMIT 8'h0d
`define ECGTR_ADDR_EDGE 8'h0e
`define ECGTR_ADDR_LEVEL 8'h0f
`define ECGTR_ADDR_CH1 8'h11
`define ECGTR_ADDR_CH2 8'h12
`define ECGTR_ADDR_CH3 8'h13
// field positions
`define ECGTR_MARGIN_MSB 19
`define ECGTR_MARGIN_LSB 16
`define ECGTR_LIMIT_MSB 15
`define ECGTR_LIMIT_LSB 0
`define ECGTR_TAG_LSB 24
// reset values (limits store bits 19:0, reserved 23:20 are not stored; edge and level store 23:0)
`define ECGTR_HIGH_RST 20'h0ffff
`define ECGTR_LOW_RST 20'h00000
`define ECGTR_EDGE_RST 24'h000000
`define ECGTR_LEVEL_RST 24'h000000
// scaling
`define ECGTR_MARGIN_SHIFT 6
`define ECGTR_LIMIT_SHIFT 9
`define ECGTR_SHORT_BITS 16
`endif

// ===== core/ecgtr_pkg.sv
package ecgtr_pkg;
  typedef enum logic [1:0] {
    ECGTR_RATE_2K = 2'b00,
    ECGTR_RATE_16K = 2'b01,
    ECGTR_RATE_128K = 2'b10,
    ECGTR_RATE_31HZ = 2'b11
  } ecgtr_rate_t;
endpackage : ecgtr_pkg

// ===== core/ecgtr_chan.sv
`timescale 1ns/10ps
`include "ecgtr_map.svh"
module ecgtr_chan #(
  parameter int DW = 24
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // conversion input
  input wire logic conv_valid,
  input wire logic [DW-1:0] conv_data,
  input wire logic chan_enable,
  // configuration
  input wire logic signed_fmt,
  input wire logic short_word,
  input wire logic ac_mode,
  input wire logic [3:0] high_margin,
  input wire logic [3:0] low_margin,
  input wire logic [15:0] high_limit,
  input wire logic [15:0] low_limit,
  input wire logic flag_clear,
  // results
  output logic [DW-1:0] sample,
  output logic range_err,
  output logic leadoff
);
  logic [DW:0] ob, hi_thr, lo_thr, lof_hi_thr, lof_lo_thr;
  logic take, over, under, lof;
  logic [DW-1:0] next_sample;
  logic next_range_err, next_leadoff;

  always_comb begin
    // offset binary makes signed and unsigned share one comparator
    ob = {1'b0, (signed_fmt ? {~conv_data[DW-1], conv_data[DW-2:0]} : conv_data)};
    hi_thr = {1'b0, {DW{1'b1}}} - ((DW+1)'(high_margin) << `ECGTR_MARGIN_SHIFT);
    lo_thr = (DW+1)'(low_margin) << `ECGTR_MARGIN_SHIFT;
    lof_hi_thr = (DW+1)'(high_limit) << `ECGTR_LIMIT_SHIFT;
    lof_lo_thr = (DW+1)'(low_limit) << `ECGTR_LIMIT_SHIFT;
    over = (high_margin != 4'h0) && (ob > hi_thr);
    under = (low_margin != 4'h0) && (ob < lo_thr);
    lof = ac_mode && ((ob >= lof_hi_thr) || (ob <= lof_lo_thr));
    take = conv_valid && chan_enable;
    next_sample = sample;
    if (take) begin
      // msb-justified; at the fast rate only 16 bits carry meaning
      if (short_word) begin
        next_sample = {conv_data[DW-1 -: `ECGTR_SHORT_BITS],
                       (DW-`ECGTR_SHORT_BITS)'(0)};
      end else begin
        next_sample = conv_data;
      end
    end
    // a new event beats a clear in the same cycle
    next_range_err = (range_err && !flag_clear) || (take && (over || under));
    next_leadoff = (leadoff && !flag_clear) || (take && lof);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sample <= '0;
      range_err <= 1'b0;
      leadoff <= 1'b0;
    end else begin
      sample <= next_sample;
      range_err <= next_range_err;
      leadoff <= next_leadoff;
    end
  end

  property p_set_beats_clear;
    @(posedge sys_clk) disable iff (!nrst)
    (take && (over || under) && flag_clear) |=> range_err;
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("range flag lost when set and clear collide");
endmodule : ecgtr_chan

// ===== tb/ecgtr_host.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// host side of the register port, changes only just after a rising edge
module ecgtr_host (
  // clock
  input wire logic sys_clk,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic frame_rd,
  output logic [7:0] reg_addr,
  output logic [23:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    frame_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
  end
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    logic [23:0] v;
    v = d;
    if (a == 8'h0c || a == 8'h0d) v[23:20] = 4'h0;
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    // released lines toggle so a stale value never looks live
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic fr, output logic [31:0] q);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    frame_rd <= fr;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    frame_rd <= ~fr;
    reg_addr <= ~a;
    // taken at the edge that samples reg_rvalid high, before it drops
    @(posedge sys_clk);
    q = (reg_rvalid === 1'b1) ? reg_rdata : 32'hxxxxxxxx;
  endtask : rd
endmodule : ecgtr_host

// ===== tb/tb_ecgtr_regs.sv
`timescale 1ns/10ps
module tb_ecgtr_regs;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr, reg_rd, frame_rd, reg_rvalid, rd_short, ac_leadoff_mode, flag_clear;
  logic [7:0] reg_addr, pace_amplitude_limit;
  logic [23:0] reg_wdata, pace_edge_eff, pace_level_limits;
  logic [31:0] reg_rdata, q;
  logic [1:0] output_rate_select;
  logic output_format_select;
  logic [2:0] conv_valid, chan_enable, range_err, leadoff;
  logic [71:0] conv_data;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  // data, range error, lead-off for margins 2/3 and limits 0x4000/0x0010
  localparam logic [25:0] TBL [8] = '{{24'h7fffff, 2'b00}, {24'h800000, 2'b01},
    {24'hffff7f, 2'b01}, {24'hffff80, 2'b11}, {24'h002001, 2'b00},
    {24'h002000, 2'b01}, {24'h0000c0, 2'b01}, {24'h0000bf, 2'b11}};
  always #5 sys_clk = ~sys_clk;
  ecgtr_regs #(.DW(24)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .frame_rd(frame_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rd_short(rd_short),
    .output_rate_select(output_rate_select), .output_format_select(output_format_select),
    .ac_leadoff_mode(ac_leadoff_mode), .pace_amplitude_limit(pace_amplitude_limit),
    .conv_valid(conv_valid), .conv_data(conv_data), .chan_enable(chan_enable),
    .flag_clear(flag_clear), .range_err(range_err), .leadoff(leadoff),
    .pace_edge_eff(pace_edge_eff), .pace_level_limits(pace_level_limits));
  ecgtr_host host_u (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .frame_rd(frame_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic cv(input int g, input logic [23:0] d);
    @(posedge sys_clk);
    conv_valid <= 3'b001 << g;
    conv_data[24*g +: 24] <= d;
    @(posedge sys_clk);
    conv_valid <= 3'b000;
    @(posedge sys_clk);
    #1;
  endtask : cv
  task automatic clr;
    @(posedge sys_clk);
    flag_clear <= 1'b1;
    @(posedge sys_clk);
    flag_clear <= 1'b0;
  endtask : clr
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    host_u.rd(8'h0c, 1'b0, q); chk("high_limit", q, 32'h0000ffff);
    host_u.rd(8'h0d, 1'b0, q); chk("low_limit", q, 32'h00000000);
    host_u.rd(8'h0e, 1'b0, q); chk("edge", q, 32'h00000000);
    host_u.rd(8'h20, 1'b0, q); chk("unmapped", q, 32'h00000000);
    chk("edge_eff", pace_edge_eff, 32'h00202020);
    $display("test reset done");
  endtask : t_reset
  task automatic t_range;
    host_u.wr(8'h0c, 24'hf24000);
    host_u.wr(8'h0d, 24'h030010);
    host_u.rd(8'h0c, 1'b0, q); chk("high_limit", q, 32'h00024000);
    host_u.rd(8'h0d, 1'b0, q); chk("low_limit", q, 32'h00030010);
    for (int i = 0; i < 8; i++) begin
      clr();
      cv(0, TBL[i][25:2]);
      chk("range_err", range_err[0], TBL[i][1]);
      chk("leadoff", leadoff[0], TBL[i][0]);
    end
    cv(0, 24'h7fffff);
    chk("sticky", {range_err[0], leadoff[0]}, 32'h3);
    cv(1, 24'h000100); chk("leadoff_ch2", leadoff[1], 32'h1);
    host_u.rd(8'h11, 1'b0, q); chk("ch1", q, 32'h117fffff);
    @(posedge sys_clk) ac_leadoff_mode <= 1'b0;
    clr();
    cv(0, 24'h800000); chk("leadoff_dc", leadoff[0], 32'h0);
    @(posedge sys_clk) chan_enable <= 3'b101;
    cv(1, 24'hffffff); chk("disabled", range_err[1], 32'h0);
    @(posedge sys_clk) chan_enable <= 3'b111;
    host_u.wr(8'h0c, 24'h004000);
    clr();
    cv(0, 24'hffffff); chk("margin_off", range_err[0], 32'h0);
    host_u.wr(8'h0c, 24'h024000);
    // conversion and clear on one edge: the new event must survive
    @(posedge sys_clk);
    flag_clear <= 1'b1;
    conv_valid <= 3'b001;
    conv_data[23:0] <= 24'hffffff;
    @(posedge sys_clk);
    flag_clear <= 1'b0;
    conv_valid <= 3'b000;
    @(posedge sys_clk);
    #1;
    chk("set_wins", range_err[0], 32'h1);
    $display("test range done");
  endtask : t_range
  task automatic t_format;
    @(posedge sys_clk) output_format_select <= 1'b0;
    clr();
    cv(0, 24'h7fffff); chk("signed_max", range_err[0], 32'h1);
    clr();
    cv(0, 24'h000000); chk("signed_zero", range_err[0], 32'h0);
    @(posedge sys_clk) output_format_select <= 1'b1;
    clr();
    cv(0, 24'h000000); chk("unsigned_zero", range_err[0], 32'h1);
    @(posedge sys_clk) output_format_select <= 1'b0;
    @(posedge sys_clk) output_rate_select <= 2'b10;
    clr();
    cv(0, 24'h7fffff); chk("forced_fmt", range_err[0], 32'h0);
    @(posedge sys_clk) output_format_select <= 1'b1;
    $display("test format done");
  endtask : t_format
  task automatic t_rate;
    for (int r = 0; r < 4; r++) begin
      @(posedge sys_clk) output_rate_select <= r[1:0];
      cv(1, 24'h123456);
      host_u.rd(8'h12, 1'b0, q);
      chk("reg_read", q, (r == 2) ? 32'h12123400 : 32'h12123456);
      host_u.rd(8'h12, 1'b1, q);
      chk("frame_read", q, (r == 2) ? 32'h00001212 : 32'h12123456);
      chk("rd_short", rd_short, (r == 2) ? 32'h1 : 32'h0);
    end
    @(posedge sys_clk) output_rate_select <= 2'b00;
    cv(2, 24'hc0ffee);
    host_u.wr(8'h13, 24'h000000);
    host_u.rd(8'h13, 1'b0, q); chk("ch3", q, 32'h13c0ffee);
    $display("test rate done");
  endtask : t_rate
  task automatic t_pace;
    host_u.wr(8'h0e, 24'h0005ff);
    host_u.wr(8'h0f, 24'hff0180);
    @(posedge sys_clk) pace_amplitude_limit <= 8'h11;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("edge_eff", pace_edge_eff, 32'h000805ff);
    chk("level", pace_level_limits, 32'h00ff0180);
    host_u.rd(8'h0e, 1'b0, q); chk("edge", q, 32'h000005ff);
    host_u.rd(8'h0f, 1'b0, q); chk("level_rd", q, 32'h00ff0180);
    $display("test pace done");
  endtask : t_pace
  //////////////////////////////////////////////////////////////////////////////
  // ceiling well above the fewer than two hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    output_rate_select = 2'b00;
    output_format_select = 1'b1;
    ac_leadoff_mode = 1'b1;
    pace_amplitude_limit = 8'h40;
    conv_valid = 3'b000;
    conv_data = '0;
    chan_enable = 3'b111;
    flag_clear = 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_range();
    t_format();
    t_rate();
    t_pace();
    end_sim();
  end
endmodule : tb_ecgtr_regs
